// ### rxc_pkg.sv
// package for the receive configuration and converter test register bank
// assumes a classic wishbone slave with 32-bit data and byte addresses
package rxc_pkg;
	// ----------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] RXC_OFF_RX_CFG = 8'h14;
	localparam logic [7:0] RXC_OFF_RXTX_CFG = 8'h16;
	localparam logic [7:0] RXC_OFF_CONV_CLK = 8'h18;
	localparam logic [7:0] RXC_OFF_PWR_DN = 8'h1a;
	localparam logic [7:0] RXC_OFF_FMT_MON = 8'h1c;
	localparam logic [7:0] RXC_OFF_EXT_CFG = 8'h28;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] RXC_RST_REG = 8'h00;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int RXC_B_AGC_FREEZE = 7;
	localparam int RXC_B_EST_LATE = 6;
	localparam int RXC_B_SYM_EQ_DIS = 5;
	localparam int RXC_B_CHIP_EQ_DIS = 4;
	localparam int RXC_B_RDY_SFD = 3;
	localparam int RXC_B_SLOT_DIV = 2;
	localparam int RXC_B_ANT_LVL = 1;
	localparam int RXC_B_SINGLE_ANT = 0;
	localparam int RXC_B_CONT_CLK = 7;
	localparam int RXC_B_SHORT_TEST = 4;
	localparam int RXC_B_CCA_SAMPLED = 3;
	localparam int RXC_B_CLK_SERIAL = 7;
	localparam int RXC_B_MANUAL_PD = 0;
	localparam int RXC_B_OFFSET_BIN = 7;
	localparam int RXC_B_SAMPLE_TIME = 0;
	localparam int RXC_B_LOWRATE_SEL = 1;
	// ----------------------------------------
	// monitor codes
	// ----------------------------------------
	localparam logic [2:0] RXC_MON_TXF = 3'h0;
	localparam logic [2:0] RXC_MON_DNC = 3'h1;
	localparam logic [2:0] RXC_MON_CHIP = 3'h2;
	localparam logic [2:0] RXC_MON_ADC = 3'h3;
	localparam logic [2:0] RXC_MON_WALSH = 3'h4;
	localparam logic [2:0] RXC_MON_WEIGHTS = 3'h5;
	localparam logic [2:0] RXC_MON_TBUS = 3'h6;
	localparam logic [2:0] RXC_MON_CORR = 3'h7;
	localparam logic [5:0] RXC_SYNC_NEG = 6'h20;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int RXC_CLK_MHZ = 25;
	localparam int RXC_SLOT_NS = 20000;
	localparam int RXC_T_LATE_NS = 18700;
	localparam int RXC_T_EARLY_NS = 15800;
	localparam int RXC_SLOT_CYC = RXC_SLOT_NS * RXC_CLK_MHZ / 1000;
	localparam int RXC_LATE_CYC = (RXC_T_LATE_NS * RXC_CLK_MHZ + 999) / 1000;
	localparam int RXC_EARLY_CYC = (RXC_T_EARLY_NS * RXC_CLK_MHZ + 999) / 1000;
	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic [5:0] i;
		logic [5:0] q;
	} rxc_iq_t;
	typedef struct packed {
		logic standby;
		logic tx_sleep;
		logic rx_sleep;
		logic iq_sleep;
		logic ana_tx_off;
		logic ana_rx_off;
		logic ana_standby;
	} rxc_pd_t;
endpackage

// ### rxc_regs.sv
// receive configuration and converter test register bank with its steering logic
// assumes a classic wishbone master on core_clk_i; status pins arrive asynchronously
//
// Contract
// - receive bit7 one freezes agc during packets
// - receive bit6 one gates estimator clocks until detect
// - bits 5 and 4 disable the equalizers
// - bit3 picks ready after sfd versus crc
// - slot diversity bit stops switching in second half
// - single antenna drives select pin from bit1
// - bit0 picks single or dual antenna acquisition
// - continuous clock bit keeps receive clocks running
// - short test bit uses long preamble length
// - raw cca follows detect indications immediately
// - sampled cca updates once per 20us slot
// - bits 2..0 give estimator precursor
// - converter clock bit7 selects serial input clock
// - bits 6..0 gate converter clocks, one disables
// - power down bit0 selects manual power control
// - manual bits 7..1 drive power down signals
// - format bit7 selects offset binary output
// - bits 6..4 select monitor dac source
// - codes 010 and 100 route timing, walsh
// - code 101 rotates filter weights with sync
// - sample time bit picks 18.7 or 15.8us
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module rxc_regs #(
	parameter int SLOT_CYC = rxc_pkg::RXC_SLOT_CYC,
	parameter int LATE_CYC = rxc_pkg::RXC_LATE_CYC,
	parameter int EARLY_CYC = rxc_pkg::RXC_EARLY_CYC
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rstn_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// receiver events, asynchronous
	input wire logic packet_active_i,
	input wire logic signal_detect_i,
	input wire logic sfd_found_i,
	input wire logic crc_ok_i,
	input wire logic energy_detect_i,
	input wire logic carrier_sense_i,
	input wire logic signal_quality_i,
	input wire logic transmit_enable_input_i,
	input wire logic receive_enable_input_i,
	input wire logic div_ant_i,
	// preamble length registers held elsewhere
	input wire logic [7:0] short_preamble_length_reg_i,
	input wire logic [7:0] long_preamble_length_reg_i,
	// monitor sources, same clock
	input wire rxc_pkg::rxc_iq_t mon_txf_i,
	input wire rxc_pkg::rxc_iq_t mon_dnc_i,
	input wire rxc_pkg::rxc_iq_t mon_adc_i,
	input wire rxc_pkg::rxc_iq_t mon_corr_i,
	input wire rxc_pkg::rxc_iq_t mon_low_i,
	input wire logic [5:0] chip_timing_accumulator_i,
	input wire logic [5:0] walsh_winner_i_i,
	input wire logic [5:0] walsh_winner_q_i,
	input wire logic [95:0] channel_matched_filter_i,
	input wire logic [5:0] test_bus_i,
	// receiver controls
	output logic agc_freeze_o,
	output logic est_clk_en_o,
	output logic intersymbol_equalizer_en_o,
	output logic interchip_equalizer_en_o,
	output logic receive_data_ready_o,
	output logic ant_sel_o,
	output logic cca_o,
	output logic [2:0] precursor_o,
	output logic [7:0] preamble_len_o,
	// converter controls
	output logic conv_clk_serial_o,
	output logic [6:0] conv_clk_en_o,
	output rxc_pkg::rxc_pd_t pd_o,
	output logic adc_offset_bin_o,
	output rxc_pkg::rxc_iq_t mon_dac_o
);
	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	logic [7:0] rx_cfg_q, rxtx_cfg_q, conv_clk_q, pwr_dn_q, fmt_mon_q, ext_cfg_q;
	logic ack_q;
	logic [31:0] dat_q;
	wire req = wb_cyc_i && wb_stb_i && !ack_q;
	wire wr_lane0 = req && wb_we_i && wb_sel_i[0];
	wire hit_rx = wb_adr_i == rxc_pkg::RXC_OFF_RX_CFG;
	wire hit_rxtx = wb_adr_i == rxc_pkg::RXC_OFF_RXTX_CFG;
	wire hit_clk = wb_adr_i == rxc_pkg::RXC_OFF_CONV_CLK;
	wire hit_pd = wb_adr_i == rxc_pkg::RXC_OFF_PWR_DN;
	wire hit_fmt = wb_adr_i == rxc_pkg::RXC_OFF_FMT_MON;
	wire hit_ext = wb_adr_i == rxc_pkg::RXC_OFF_EXT_CFG;
	// unmapped addresses still ack and read zero, so a stray access never hangs
	wire [7:0] rd_byte = hit_rx ? rx_cfg_q : hit_rxtx ? rxtx_cfg_q : hit_clk ? conv_clk_q :
		hit_pd ? pwr_dn_q : hit_fmt ? fmt_mon_q : hit_ext ? ext_cfg_q : 8'h00;

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= req;
			dat_q <= {24'h00_0000, rd_byte};
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rx_cfg_q <= rxc_pkg::RXC_RST_REG;
			rxtx_cfg_q <= rxc_pkg::RXC_RST_REG;
			conv_clk_q <= rxc_pkg::RXC_RST_REG;
			pwr_dn_q <= rxc_pkg::RXC_RST_REG;
			fmt_mon_q <= rxc_pkg::RXC_RST_REG;
			ext_cfg_q <= rxc_pkg::RXC_RST_REG;
		end else if (wr_lane0) begin
			if (hit_rx) rx_cfg_q <= wb_dat_i[7:0];
			if (hit_rxtx) rxtx_cfg_q <= wb_dat_i[7:0];
			if (hit_clk) conv_clk_q <= wb_dat_i[7:0];
			if (hit_pd) pwr_dn_q <= wb_dat_i[7:0];
			if (hit_fmt) fmt_mon_q <= wb_dat_i[7:0];
			if (hit_ext) ext_cfg_q <= {6'h00, wb_dat_i[1:0]};
		end
	end

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	localparam int NS = 10;
	wire [NS-1:0] async_in = {packet_active_i, signal_detect_i, sfd_found_i, crc_ok_i,
		energy_detect_i, carrier_sense_i, signal_quality_i, transmit_enable_input_i,
		receive_enable_input_i, div_ant_i};
	logic [NS-1:0] meta_q, sync_q;
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end
	wire s_pkt = sync_q[9];
	wire s_det = sync_q[8];
	wire s_sfd = sync_q[7];
	wire s_crc = sync_q[6];
	wire s_energy = sync_q[5];
	wire s_cs = sync_q[4];
	wire s_sq = sync_q[3];
	wire s_txe = sync_q[2];
	wire s_rxe = sync_q[1];
	wire s_div = sync_q[0];

	// ----------------------------------------
	// slot timer and cca
	// ----------------------------------------
	logic [15:0] slot_q;
	logic cca_samp_q;
	wire slot_end = slot_q == 16'(SLOT_CYC - 1);
	wire [15:0] sample_at = ext_cfg_q[rxc_pkg::RXC_B_SAMPLE_TIME] ?
		16'(EARLY_CYC) : 16'(LATE_CYC);
	wire cca_raw = s_energy || s_cs || s_sq;
	wire second_half = slot_q >= 16'(SLOT_CYC / 2);
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			slot_q <= 16'h0000;
			cca_samp_q <= 1'b0;
		end else begin
			slot_q <= slot_end ? 16'h0000 : slot_q + 16'h0001;
			if (slot_q == sample_at - 16'h0001) cca_samp_q <= cca_raw;
		end
	end
	// raw mode tracks synchronised indications with no slot wait
	wire cca_d = rxtx_cfg_q[rxc_pkg::RXC_B_CCA_SAMPLED] ? cca_samp_q : cca_raw;

	// ----------------------------------------
	// receive steering
	// ----------------------------------------
	wire single = rx_cfg_q[rxc_pkg::RXC_B_SINGLE_ANT];
	wire div_ok = !(rx_cfg_q[rxc_pkg::RXC_B_SLOT_DIV] && second_half);
	logic div_hold_q;
	wire ant_d = single ? rx_cfg_q[rxc_pkg::RXC_B_ANT_LVL] :
		(div_ok ? s_div : div_hold_q);
	wire rdy_d = rx_cfg_q[rxc_pkg::RXC_B_RDY_SFD] ? s_sfd : s_crc;
	// continuous clocking wins over the detect gate
	wire est_d = rxtx_cfg_q[rxc_pkg::RXC_B_CONT_CLK] ||
		!rx_cfg_q[rxc_pkg::RXC_B_EST_LATE] || s_det;
	wire [7:0] pre_d = rxtx_cfg_q[rxc_pkg::RXC_B_SHORT_TEST] ?
		long_preamble_length_reg_i : short_preamble_length_reg_i;
	wire [6:0] pd_auto = {!(s_txe || s_rxe), !s_txe, !s_rxe, !s_rxe, !s_txe, !s_rxe,
		!(s_txe || s_rxe)};
	wire [6:0] pd_d = pwr_dn_q[rxc_pkg::RXC_B_MANUAL_PD] ? pwr_dn_q[7:1] : pd_auto;

	// ----------------------------------------
	// monitor dac
	// ----------------------------------------
	logic [4:0] wt_q;
	wire [3:0] wt_idx = wt_q[4:1];
	// seven bits: the last weight starts at bit 90
	wire [6:0] wt_base = {1'b0, wt_idx, 2'b00} + {2'b00, wt_idx, 1'b0};
	wire [5:0] wt_val = channel_matched_filter_i[wt_base +: 6];
	wire rxc_pkg::rxc_iq_t mon_wt = wt_q[0] ? '{i: wt_val, q: wt_val} :
		'{i: rxc_pkg::RXC_SYNC_NEG, q: rxc_pkg::RXC_SYNC_NEG};
	rxc_pkg::rxc_iq_t mon_d;
	always_comb begin
		unique case (fmt_mon_q[6:4])
			rxc_pkg::RXC_MON_TXF: mon_d = mon_txf_i;
			rxc_pkg::RXC_MON_DNC: mon_d = mon_dnc_i;
			rxc_pkg::RXC_MON_CHIP: mon_d = '{i: 6'h00, q: chip_timing_accumulator_i};
			rxc_pkg::RXC_MON_ADC: mon_d = mon_adc_i;
			rxc_pkg::RXC_MON_WALSH: mon_d = '{i: walsh_winner_i_i, q: walsh_winner_q_i};
			rxc_pkg::RXC_MON_WEIGHTS: mon_d = mon_wt;
			rxc_pkg::RXC_MON_TBUS: mon_d = '{i: test_bus_i, q: test_bus_i};
			rxc_pkg::RXC_MON_CORR: mon_d = ext_cfg_q[rxc_pkg::RXC_B_LOWRATE_SEL] ? mon_low_i : mon_corr_i;
		endcase
	end

	// ----------------------------------------
	// registered outputs
	// ----------------------------------------
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			agc_freeze_o <= 1'b0;
			est_clk_en_o <= 1'b0;
			intersymbol_equalizer_en_o <= 1'b0;
			interchip_equalizer_en_o <= 1'b0;
			receive_data_ready_o <= 1'b0;
			ant_sel_o <= 1'b0;
			div_hold_q <= 1'b0;
			cca_o <= 1'b0;
			precursor_o <= 3'h0;
			preamble_len_o <= 8'h00;
			conv_clk_serial_o <= 1'b0;
			conv_clk_en_o <= 7'h00;
			pd_o <= '0;
			adc_offset_bin_o <= 1'b0;
			mon_dac_o <= '0;
			wt_q <= 5'h00;
		end else begin
			agc_freeze_o <= rx_cfg_q[rxc_pkg::RXC_B_AGC_FREEZE] && s_pkt;
			est_clk_en_o <= est_d;
			intersymbol_equalizer_en_o <= !rx_cfg_q[rxc_pkg::RXC_B_SYM_EQ_DIS];
			interchip_equalizer_en_o <= !rx_cfg_q[rxc_pkg::RXC_B_CHIP_EQ_DIS];
			receive_data_ready_o <= rdy_d;
			ant_sel_o <= ant_d;
			div_hold_q <= ant_d;
			cca_o <= cca_d;
			precursor_o <= rxtx_cfg_q[2:0];
			preamble_len_o <= pre_d;
			conv_clk_serial_o <= conv_clk_q[rxc_pkg::RXC_B_CLK_SERIAL];
			conv_clk_en_o <= ~conv_clk_q[6:0];
			pd_o <= pd_d;
			adc_offset_bin_o <= fmt_mon_q[rxc_pkg::RXC_B_OFFSET_BIN];
			mon_dac_o <= mon_d;
			wt_q <= wt_q + 5'h01;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
endmodule
`default_nettype wire

// ### rxc_regs_props.sv
// assertions on the register bank ports, bound into rxc_regs
// assumes one-cycle wishbone ack and register data in lane 0
`timescale 1ns/100ps
`default_nettype none
module rxc_regs_props (
	// clock and bus
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o,
	// watched controls
	input wire logic intersymbol_equalizer_en_o,
	input wire logic ant_sel_o,
	input wire logic [2:0] precursor_o,
	input wire logic conv_clk_serial_o,
	input wire logic [6:0] conv_clk_en_o,
	input wire rxc_pkg::rxc_pd_t pd_o
);
	// ----------------------------------------
	// shadow of written registers
	// ----------------------------------------
	// shadow lags the bank by a cycle, so checks wait for two quiet edges
	logic [7:0] sh_q [5];
	wire logic [7:0] idx = (wb_adr_i - 8'h14) >> 1;
	wire logic hit = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0]
		& (wb_adr_i[0] == 1'b0) & (wb_adr_i >= 8'h14) & (idx < 8'h05);
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			sh_q <= '{default: 8'h00};
		else if (hit)
			sh_q[idx[2:0]] <= wb_dat_i[7:0];
	end
	wire logic [40:0] cfg_w = {rstn_i, sh_q[0], sh_q[1], sh_q[2], sh_q[3], sh_q[4]};
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rstn_i);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered next cycle");
	symbol_eq_a: assert property ($stable(cfg_w) [*2] |->
		intersymbol_equalizer_en_o == !sh_q[0][5]) else $error("symbol equalizer enable wrong");
	ant_level_a: assert property ($stable(cfg_w) [*2] ##0 sh_q[0][0] |->
		ant_sel_o == sh_q[0][1]) else $error("antenna level wrong");
	precursor_val_a: assert property ($stable(cfg_w) [*2] |->
		precursor_o == sh_q[1][2:0]) else $error("precursor wrong");
	clk_source_a: assert property ($stable(cfg_w) [*2] |->
		conv_clk_serial_o == sh_q[2][7]) else $error("converter clock source wrong");
	clk_gates_a: assert property ($stable(cfg_w) [*2] |->
		conv_clk_en_o == ~sh_q[2][6:0]) else $error("converter clock gates wrong");
	txdac_gate_a: assert property ($rose(sh_q[2][6]) |-> ##[0:3] !conv_clk_en_o[6])
		else $error("tx dac clock not gated");
	manual_pd_a: assert property ($stable(cfg_w) [*2] ##0 sh_q[3][0] |->
		pd_o == sh_q[3][7:1]) else $error("manual power down wrong");
endmodule
bind rxc_regs rxc_regs_props i_rxc_regs_props (.*);
`default_nettype wire

// ### rxc_host.sv
// wishbone master model of the host programming the bank
// assumes xfer is entered just after a rising edge of core_clk_i
`timescale 1ns/100ps
`default_nettype none
module rxc_host (
	// clock
	input wire logic core_clk_i,
	// wishbone master
	output logic wb_cyc_o,
	output logic wb_stb_o,
	output logic wb_we_o,
	output logic [7:0] wb_adr_o,
	output logic [3:0] wb_sel_o,
	output logic [31:0] wb_dat_o,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_i
);
	initial {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} = '0;
	task automatic xfer(input logic [7:0] a, input logic w, input logic [3:0] s,
		input logic [31:0] d, output logic [31:0] q);
		{wb_cyc_o, wb_stb_o, wb_we_o} <= {2'b11, w};
		wb_adr_o <= a;
		wb_sel_o <= s;
		wb_dat_o <= d;
		do
			@(posedge core_clk_i);
		while (wb_ack_i !== 1'b1);
		q = wb_dat_i;
		{wb_cyc_o, wb_stb_o, wb_we_o} <= 3'b000;
		// released lines do not keep their last value
		wb_adr_o <= ~a;
		wb_dat_o <= ~d;
		@(posedge core_clk_i);
	endtask
endmodule
`default_nettype wire

// ### tb.sv
// self-checking bench for the receive configuration register bank
// assumes rxc_host for bus cycles; status and monitor inputs come from here
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic core_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic packet_active_i = 1'b0, signal_detect_i = 1'b0, sfd_found_i = 1'b1, crc_ok_i = 1'b0;
	logic energy_detect_i = 1'b0, carrier_sense_i = 1'b0, signal_quality_i = 1'b0;
	logic div_ant_i = 1'b1, transmit_enable_input_i = 1'b1, receive_enable_input_i = 1'b0;
	logic [7:0] short_preamble_length_reg_i = 8'h11, long_preamble_length_reg_i = 8'h22;
	rxc_pkg::rxc_iq_t mon_txf_i = 12'h0c3, mon_dnc_i = 12'h145, mon_adc_i = 12'h1c7;
	rxc_pkg::rxc_iq_t mon_corr_i = 12'h249, mon_low_i = 12'h2cb, mon_dac_o;
	logic [5:0] chip_timing_accumulator_i = 6'h2b, walsh_winner_i_i = 6'h0c;
	logic [5:0] walsh_winner_q_i = 6'h31, test_bus_i = 6'h17;
	logic [95:0] channel_matched_filter_i = {16{6'h01}};
	logic agc_freeze_o, est_clk_en_o, intersymbol_equalizer_en_o, interchip_equalizer_en_o;
	logic receive_data_ready_o, ant_sel_o, cca_o, conv_clk_serial_o, adc_offset_bin_o;
	logic [2:0] precursor_o;
	logic [7:0] preamble_len_o;
	logic [6:0] conv_clk_en_o;
	rxc_pkg::rxc_pd_t pd_o;
	int err_count = 0, check_count = 0;
	always #20 core_clk_i = ~core_clk_i;
	rxc_host i_rxc_host (.core_clk_i, .wb_cyc_o(wb_cyc_i), .wb_stb_o(wb_stb_i),
		.wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i), .wb_dat_o(wb_dat_i),
		.wb_dat_i(wb_dat_o), .wb_ack_i(wb_ack_o));
	// short slot keeps the sampled cca test brief
	rxc_regs #(.SLOT_CYC(20), .LATE_CYC(18), .EARLY_CYC(15)) i_rxc_regs (.*);
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		i_rxc_host.xfer(a, 1'b1, 4'h1, 32'(d), q);
		repeat (4) @(posedge core_clk_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
		logic [31:0] q;
		i_rxc_host.xfer(a, 1'b0, 4'h1, '0, q);
		chk(nm, q, 32'(e));
	endtask
	task automatic t_regs();
		logic [31:0] q;
		for (int k = 0; k < 5; k++)
			rd(8'h14 + 8'(2 * k), 8'h00, "reset value");
		rd(8'h28, 8'h00, "reset value");
		for (int k = 0; k < 5; k++)
			wr(8'h14 + 8'(2 * k), 8'h5a ^ 8'(k));
		for (int k = 0; k < 5; k++)
			rd(8'h14 + 8'(2 * k), 8'h5a ^ 8'(k), "readback");
		i_rxc_host.xfer(8'h14, 1'b1, 4'he, 32'h0000_00ff, q);
		rd(8'h14, 8'h5a, "lane off write");
		wr(8'h30, 8'h77);
		rd(8'h30, 8'h00, "unmapped");
		$display("test regs done");
	endtask
	task automatic t_rx();
		packet_active_i <= 1'b1;
		wr(8'h16, 8'h00);
		wr(8'h14, 8'hfb);
		chk("freeze", agc_freeze_o, 1'b1);
		chk("est clock", est_clk_en_o, 1'b0);
		chk("icie", interchip_equalizer_en_o, 1'b0);
		chk("ready sfd", receive_data_ready_o, 1'b1);
		chk("ant high", ant_sel_o, 1'b1);
		wr(8'h14, 8'h01);
		chk("no freeze", agc_freeze_o, 1'b0);
		chk("icie on", interchip_equalizer_en_o, 1'b1);
		chk("ready crc", receive_data_ready_o, 1'b0);
		chk("ant low", ant_sel_o, 1'b0);
		wr(8'h14, 8'h40);
		chk("dual ant", ant_sel_o, 1'b1);
		wr(8'h16, 8'h80);
		chk("cont clock", est_clk_en_o, 1'b1);
		wr(8'h14, 8'h04);
		while (i_rxc_regs.slot_q != 16'h000a)
			@(posedge core_clk_i);
		div_ant_i <= 1'b0;
		repeat (6) @(posedge core_clk_i);
		chk("div hold", ant_sel_o, 1'b1);
		repeat (10) @(posedge core_clk_i);
		chk("div free", ant_sel_o, 1'b0);
		div_ant_i <= 1'b1;
		$display("test rx done");
	endtask
	task automatic t_conv();
		wr(8'h18, 8'h85);
		wr(8'h1a, 8'ha5);
		chk("clock src", conv_clk_serial_o, 1'b1);
		chk("clock gates", conv_clk_en_o, 7'h7a);
		chk("manual pd", pd_o, 7'h52);
		wr(8'h1a, 8'h00);
		chk("auto pd", pd_o, 7'h1a);
		$display("test converter done");
	endtask
	task automatic t_mon();
		rxc_pkg::rxc_iq_t ex [8];
		int n;
		ex = '{mon_txf_i, mon_dnc_i, {6'h00, chip_timing_accumulator_i}, mon_adc_i,
			{walsh_winner_i_i, walsh_winner_q_i}, 12'h000, {test_bus_i, test_bus_i}, mon_corr_i};
		n = 0;
		for (int k = 0; k < 8; k++) begin
			wr(8'h1c, {1'b1, 3'(k), 4'h0});
			for (int c = 0; c < 4 && k == 5; c++) begin
				@(posedge core_clk_i);
				n += int'(mon_dac_o.i == 6'h20);
			end
			if (k != 5)
				chk("monitor", mon_dac_o, ex[k]);
		end
		chk("sync pulses", n, 2);
		chk("offset bin", adc_offset_bin_o, 1'b1);
		wr(8'h28, 8'h02);
		chk("low rate", mon_dac_o, mon_low_i);
		$display("test monitor done");
	endtask
	task automatic t_cca();
		int n;
		wr(8'h16, 8'h15);
		chk("precursor", precursor_o, 3'h5);
		chk("long len", preamble_len_o, 8'h22);
		for (int k = 0; k < 4; k++) begin
			{energy_detect_i, carrier_sense_i, signal_quality_i} <= 3'b001 << k;
			repeat (4) @(posedge core_clk_i);
			chk("raw cca", cca_o, 1'(k < 3));
		end
		wr(8'h16, 8'h08);
		chk("short len", preamble_len_o, 8'h11);
		for (int s = 0; s < 2; s++) begin
			wr(8'h28, {7'h01, 1'(s)});
			energy_detect_i <= 1'b1;
			repeat (30) @(posedge core_clk_i);
			chk("slot high", cca_o, 1'b1);
			// drop the indication at slot start: the sampled output holds until the sample point
			while (i_rxc_regs.slot_q != 16'h0000)
				@(posedge core_clk_i);
			energy_detect_i <= 1'b0;
			n = 0;
			for (int c = 0; c < 30; c++) begin
				@(posedge core_clk_i);
				n += int'(cca_o);
			end
			chk("slot hold", n, s ? 15 : 18);
			chk("slot low", cca_o, 1'b0);
		end
		$display("test cca done");
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#400_000;
		err_count++;
		report_and_stop();
	end
	initial begin
		repeat (2) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		t_regs();
		t_rx();
		t_conv();
		t_mon();
		t_cca();
		report_and_stop();
	end
endmodule
`default_nettype wire
